//--- rtl/sarseq_cfg.svh
`ifndef SARSEQ_CFG_SVH
`define SARSEQ_CFG_SVH
// Word offsets on the Avalon bus; printed offsets are not multiples of four
`define SARSEQ_IDX_CTRL1 8'h26
`define SARSEQ_IDX_CTRL2 8'h27
`define SARSEQ_IDX_RESLO 8'h28
`define SARSEQ_IDX_RESHI 8'h29
`define SARSEQ_ADDR_W 10
// Control one fields
`define SARSEQ_C1_START 7
`define SARSEQ_C1_MODE_HI 6
`define SARSEQ_C1_MODE_LO 5
`define SARSEQ_C1_GATE 4
`define SARSEQ_C1_CHAN_HI 3
`define SARSEQ_C1_RESET 8'h10
// Control two fields
`define SARSEQ_C2_LADDER 5
`define SARSEQ_C2_TIME_HI 3
`define SARSEQ_C2_TIME_LO 1
`define SARSEQ_C2_RESET 8'h10
`define SARSEQ_C2_MASK 8'h2e
`define SARSEQ_C2_FORCE1 8'h10
// Status positions in result low
`define SARSEQ_ST_DONE 5
`define SARSEQ_ST_BUSY 4
// Conversion times in fc cycles
`define SARSEQ_T000 11'd39
`define SARSEQ_T010 11'd78
`define SARSEQ_T011 11'd156
`define SARSEQ_T100 11'd312
`define SARSEQ_T101 11'd624
`define SARSEQ_T110 11'd1248
`define SARSEQ_HOLDOFF 3'd4
`endif

//--- rtl/sarseq_pkg.sv
`default_nettype none
package sarseq_pkg;
  typedef enum logic [1:0] {SARSEQ_DIS = 2'h0, SARSEQ_SW = 2'h1, SARSEQ_RSV = 2'h2,
    SARSEQ_REP = 2'h3} sarseq_mode_t;
  typedef enum logic [0:0] {ST_IDLE, ST_CONV} sarseq_state_t;
endpackage
`default_nettype wire

//--- rtl/sarseq_timer.sv
`include "sarseq_cfg.svh"
`default_nettype none
module sarseq_timer
  import sarseq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [2:0] timeSel,
  output logic expired
);
  typedef struct packed {
    logic [10:0] count;
  } sarseq_tmr_t;
  sarseq_tmr_t s_reg;
  sarseq_tmr_t s_next;
  logic [10:0] limit;

  // time code table
  // Cycle count per time code; reserved codes fall back to the longest
  function automatic logic [10:0] cyclesFor(input logic [2:0] sel);
    case (sel)
      3'h0: cyclesFor = `SARSEQ_T000;
      3'h2: cyclesFor = `SARSEQ_T010;
      3'h3: cyclesFor = `SARSEQ_T011;
      3'h4: cyclesFor = `SARSEQ_T100;
      3'h5: cyclesFor = `SARSEQ_T101;
      default: cyclesFor = `SARSEQ_T110;
    endcase
  endfunction

  assign limit = cyclesFor(timeSel);
  assign expired = run && (s_reg.count == limit - 11'h001);

  // Counter clears whenever idle or at expiry
  always_comb begin
    s_next = s_reg;
    if (!run || expired) begin
      s_next.count = 11'h000;
    end else begin
      s_next.count = s_reg.count + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // sarseq_timer
`default_nettype wire

//--- rtl/sarseq_top.sv
`include "sarseq_cfg.svh"
`default_nettype none
// Notes on behaviour
// - Reading upper result clears done flag; read low byte first.
// - Busy flag rises at conversion start, falls when it finishes. Here a mode 11 relaunch keeps it 1 between conversions.
// - Low result bits 3..0 carry no defined value.
// - Done flag reads 0 before/during conversion, 1 after; read-only. Here a mode 11 relaunch keeps it 1 through the next conversion.
// - Mode 01 plus start request converts the selected channel once.
// - Completion loads results, sets done, pulses interrupt together.
// - Start request clears itself once the conversion begins.
// - Mode 11 relaunches a conversion after each completion.
// - Writing mode 00 halts any conversion at once.
// - A halted conversion leaves result registers unchanged.
// - Restart clears done but result keeps old value until completion.
// - Completion only after the selected conversion time elapses.
// - Mode codes: 00 off, 01 software, 10 reserved, 11 repeat.
// - Time codes give 39 to 1248 fc; 001 and 111 reserved.
// - After control one written zero, start ignored four cycles.
module sarseq_top
  import sarseq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`SARSEQ_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic [1:0] avsResponse,
  input wire logic [9:0] sampleData,
  output logic [1:0] channelSel,
  output logic [3:0] channelSelRaw,
  output logic analogGateOff,
  output logic ladderOn,
  output logic sampleStrobe,
  output logic convDoneIrq
);
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [9:0] result;
    logic doneFlag;
    logic state;
    logic [2:0] holdoff;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic irq;
  } sarseq_state_reg_t;

  sarseq_state_reg_t s_reg;
  sarseq_state_reg_t s_next;
  logic expired;
  logic [1:0] modeNow;
  logic accessReq;
  logic wrLow;
  logic [7:0] wbyte;
  logic [7:0] idx;
  logic mapped;
  logic [9:0] sampleS1_reg;
  logic [9:0] sampleS2_reg;

  // Word index from byte address
  function automatic logic [7:0] wordIdx(input logic [`SARSEQ_ADDR_W-1:0] a);
    wordIdx = a[9:2];
  endfunction

  assign idx = wordIdx(avsAddress);
  assign mapped = (idx >= `SARSEQ_IDX_CTRL1) && (idx <= `SARSEQ_IDX_RESHI);
  assign accessReq = (avsRead || avsWrite) && !s_reg.ack;
  // Writes land only at the edge where waitrequest is seen low
  assign wrLow = avsWrite && s_reg.ack && avsByteenable[0];
  assign wbyte = avsWritedata[7:0];
  assign modeNow = s_reg.ctrl1[`SARSEQ_C1_MODE_HI:`SARSEQ_C1_MODE_LO];

  // Analog result arrives from another domain; two stages before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleS1_reg <= 10'h000;
      sampleS2_reg <= 10'h000;
    end else begin
      sampleS1_reg <= sampleData;
      sampleS2_reg <= sampleS1_reg;
    end
  end

  // Timer runs only while converting
  sarseq_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(s_reg.state == ST_CONV),
    .timeSel(s_reg.ctrl2[`SARSEQ_C2_TIME_HI:`SARSEQ_C2_TIME_LO]),
    .expired(expired)
  );

  // Register file, sequencer and result path
  always_comb begin
    logic startNow;
    logic haltNow;
    logic doneEvt;
    logic hiRead;
    startNow = 1'b0;
    haltNow = 1'b0;
    doneEvt = 1'b0;
    hiRead = 1'b0;
    s_next = s_reg;
    s_next.ack = accessReq;
    s_next.irq = 1'b0;
    if (s_reg.holdoff != 3'h0) begin
      s_next.holdoff = s_reg.holdoff - 3'h1;
    end

    // Bus writes; read-only registers silently ignore writes
    if (wrLow && idx == `SARSEQ_IDX_CTRL1) begin
      s_next.ctrl1 = wbyte;
      if (wbyte == 8'h00) begin
        s_next.holdoff = `SARSEQ_HOLDOFF;
      end
      if (wbyte[`SARSEQ_C1_MODE_HI:`SARSEQ_C1_MODE_LO] == SARSEQ_DIS) begin
        haltNow = 1'b1;
      end
    end else if (wrLow && idx == `SARSEQ_IDX_CTRL2) begin
      s_next.ctrl2 = (wbyte & `SARSEQ_C2_MASK) | `SARSEQ_C2_FORCE1;
    end

    if (avsRead && s_reg.ack && idx == `SARSEQ_IDX_RESHI) begin
      hiRead = 1'b1;
    end

    if (s_reg.state == ST_CONV && expired && !haltNow) begin
      doneEvt = 1'b1;
    end

    // start only in a run mode and outside holdoff
    if (s_reg.ctrl1[`SARSEQ_C1_START] && s_reg.holdoff == 3'h0 && !haltNow
        && (modeNow == SARSEQ_SW || modeNow == SARSEQ_REP)
        && (s_reg.state == ST_IDLE || doneEvt)) begin
      startNow = 1'b1;
    end
    if (doneEvt && modeNow == SARSEQ_REP) begin
      startNow = 1'b1;
    end

    if (haltNow) begin
      s_next.state = ST_IDLE;
    end else if (startNow) begin
      s_next.state = ST_CONV;
    end else if (doneEvt) begin
      s_next.state = ST_IDLE;
    end

    if (startNow) begin
      s_next.ctrl1[`SARSEQ_C1_START] = 1'b0;
    end

    // load, flag, irq together; halted run never gets here
    if (doneEvt) begin
      s_next.result = sampleS2_reg;
      s_next.irq = 1'b1;
    end

    // done: set wins over clear, new start clears
    if (doneEvt) begin
      s_next.doneFlag = 1'b1;
    end else if (hiRead || startNow) begin
      s_next.doneFlag = 1'b0;
    end

    // Read data, latched so it stands with the ack
    s_next.rdata = 32'h0000_0000;
    case (idx)
      `SARSEQ_IDX_CTRL1: s_next.rdata[7:0] = s_reg.ctrl1;
      `SARSEQ_IDX_CTRL2: s_next.rdata[7:0] = s_reg.ctrl2;
      // low nibble undefined, driven zero here
      `SARSEQ_IDX_RESLO: s_next.rdata[7:0] = {s_reg.result[1:0], s_reg.doneFlag,
        s_reg.state == ST_CONV, 4'h0};
      `SARSEQ_IDX_RESHI: s_next.rdata[7:0] = s_reg.result[9:2];
      default: s_next.rdata = 32'h0000_0000;
    endcase
    // Unmapped addresses answer with a slave error
    s_next.resp = mapped ? 2'h0 : 2'h2;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.ctrl1 <= `SARSEQ_C1_RESET;
      s_reg.ctrl2 <= `SARSEQ_C2_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // One wait cycle per access; ack drops waitrequest
  assign avsWaitrequest = !s_reg.ack;
  assign avsReaddata = s_reg.rdata;
  assign avsResponse = s_reg.resp;
  assign channelSelRaw = s_reg.ctrl1[`SARSEQ_C1_CHAN_HI:0];
  assign channelSel = s_reg.ctrl1[1:0];
  assign analogGateOff = s_reg.ctrl1[`SARSEQ_C1_GATE];
  // Ladder connected always, or only during conversion
  assign ladderOn = s_reg.ctrl2[`SARSEQ_C2_LADDER] || (s_reg.state == ST_CONV);
  assign sampleStrobe = s_reg.irq;
  assign convDoneIrq = s_reg.irq;
endmodule // sarseq_top
`default_nettype wire

//--- verif/sarseq_props.sv
`include "sarseq_cfg.svh"
`default_nettype none
module sarseq_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`SARSEQ_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic [1:0] avsResponse,
  input wire logic sampleStrobe,
  input wire logic convDoneIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic req;
  logic mapped;
  logic offWr;
  // Bus request and decode helpers
  assign req = avsRead | avsWrite;
  assign mapped = avsAddress[9:2] inside {[`SARSEQ_IDX_CTRL1:`SARSEQ_IDX_RESHI]};
  assign offWr = avsWrite && !avsWaitrequest && avsWritedata[6:5] == 2'h0 &&
    avsAddress[9:2] == `SARSEQ_IDX_CTRL1;
  property p_ack;
    req && avsWaitrequest |=> !avsWaitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_one;
    !avsWaitrequest |=> avsWaitrequest;
  endproperty
  a_one: assert property (p_one) else $error("wait low too long");
  property p_hi;
    !avsWaitrequest |-> avsReaddata[31:8] == 24'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper read lanes not zero");
  property p_bad;
    !avsWaitrequest && req && !mapped |-> avsResponse == 2'h2;
  endproperty
  a_bad: assert property (p_bad) else $error("unmapped not flagged");
  property p_ok;
    !avsWaitrequest && req && mapped |-> avsResponse == 2'h0;
  endproperty
  a_ok: assert property (p_ok) else $error("mapped access flagged");
  property p_pair;
    sampleStrobe == convDoneIrq;
  endproperty
  a_pair: assert property (p_pair) else $error("strobe and irq apart");
  property p_pulse;
    convDoneIrq |=> (!convDoneIrq)[*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("completions too close");
  // One edge of slack: a completion on the disabling edge is already blocked by the halt
  property p_halt;
    offWr |-> ##2 (!convDoneIrq)[*8];
  endproperty
  a_halt: assert property (p_halt) else $error("completion after disable");
  c_irq: cover property (convDoneIrq);
  c_bad: cover property (!avsWaitrequest && req && !mapped);
  c_halt: cover property (offWr);
endmodule // sarseq_props
bind sarseq_top sarseq_props u_props (.*);
`default_nettype wire

//--- verif/sarseq_tb.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
  logic [9:0] avsAddress = 10'h000, sampleData = 10'h000;
  logic [31:0] avsWritedata = 32'h0, avsReaddata;
  logic [3:0] avsByteenable = 4'hf, channelSelRaw;
  logic [1:0] avsResponse, channelSel, rsp;
  logic avsWaitrequest, analogGateOff, ladderOn, sampleStrobe, convDoneIrq;
  logic [7:0] q;
  int nFail = 0, totalChecks = 0, nIrq = 0;
  sarseq_top DUT (.*);
  // Clock and completion count
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (convDoneIrq === 1'b1) nIrq <= nIrq + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One access; an idle edge after it keeps drivers single per step
  task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d);
    avsAddress <= a;
    avsWritedata <= {24'h0, d};
    avsRead <= ~wr;
    avsWrite <= wr;
    @(posedge clk);
    while (avsWaitrequest !== 1'b0) @(posedge clk);
    q = avsReaddata[7:0];
    rsp = avsResponse;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset();
    acc(0, 10'h098, 8'h00); chk(q, 8'h10);
    acc(0, 10'h09c, 8'h00); chk(q, 8'h10);
    acc(0, 10'h0a0, 8'h00); chk(q & 8'hf0, 8'h00);
    acc(0, 10'h000, 8'h00); chk(rsp, 2'h2);
  endtask
  task automatic t_single();
    sampleData <= 10'h2b5;
    acc(1, 10'h09c, 8'h10);
    acc(1, 10'h098, 8'h23);
    acc(1, 10'h098, 8'ha3);
    chk(channelSel, 2'h3);
    acc(0, 10'h0a0, 8'h00); chk(q & 8'hf0, 8'h10);
    acc(0, 10'h098, 8'h00); chk(q, 8'h23);
    while (nIrq < 1) @(posedge clk);
    acc(0, 10'h0a0, 8'h00); chk(q & 8'hf0, 8'h60);
    acc(0, 10'h0a4, 8'h00); chk(q, 8'had);
    acc(0, 10'h0a0, 8'h00); chk(q & 8'hf0, 8'h40);
  endtask
  task automatic t_restart();
    sampleData <= 10'h0fe;
    acc(1, 10'h098, 8'ha3);
    while (nIrq < 2) @(posedge clk);
    sampleData <= 10'h301;
    acc(1, 10'h098, 8'ha3);
    acc(0, 10'h0a0, 8'h00); chk(q & 8'hf0, 8'h90);
    acc(0, 10'h0a4, 8'h00); chk(q, 8'h3f);
    while (nIrq < 3) @(posedge clk);
    acc(0, 10'h0a4, 8'h00); chk(q, 8'hc0);
  endtask
  task automatic t_repeat();
    sampleData <= 10'h3c0;
    acc(1, 10'h098, 8'he3);
    while (nIrq < 5) @(posedge clk);
    acc(0, 10'h0a0, 8'h00); chk(q & 8'h10, 8'h10);
    sampleData <= 10'h155;
    acc(1, 10'h098, 8'h03);
    repeat (60) @(posedge clk);
    chk(nIrq, 5);
    acc(0, 10'h0a4, 8'h00); chk(q, 8'hf0);
    acc(0, 10'h0a0, 8'h00); chk(q & 8'h10, 8'h00);
    acc(1, 10'h098, 8'hc3);
    repeat (60) @(posedge clk);
    chk(nIrq, 5);
  endtask
  // Start right after a zero write must wait out the holdoff
  task automatic t_holdoff();
    acc(1, 10'h098, 8'h00);
    acc(1, 10'h098, 8'ha3);
    acc(0, 10'h0a0, 8'h00); chk(q & 8'h10, 8'h00);
    while (nIrq < 6) @(posedge clk);
    acc(0, 10'h0a0, 8'h00); chk(q & 8'h30, 8'h20);
  endtask
  // Reserved codes run the longest time, as chosen
  task automatic t_times();
    int tab[8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248};
    int k;
    int m;
    for (int c = 0; c < 8; c++) begin
      acc(1, 10'h09c, {4'h1, c[2:0], 1'b0});
      acc(1, 10'h098, 8'ha3);
      k = 0;
      m = nIrq;
      while (nIrq == m) begin
        @(posedge clk);
        k++;
      end
      chk(k >= tab[c] && k <= tab[c] + 6, 1'b1);
    end
  endtask
  task automatic wrapUp();
    $display("checks=%0d fails=%0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog well beyond the longest expected run
  initial begin
    #400000;
    nFail++;
    wrapUp();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_single();
    t_restart();
    t_repeat();
    t_holdoff();
    t_times();
    wrapUp();
  end
endmodule // testbench
`default_nettype wire
